// [include/l3hc_pkg.sv]
// shared constants and types for the layer 3 header classifier
package l3hc_pkg;
  // ----------------------------------------
  // header layout
  // ----------------------------------------
  localparam logic [7:0] PD_VALUE = 8'h48;
  localparam int HDR_LEN = 4;
  localparam int MT_POS = 3;
  localparam int MT_SPARE_BIT = 7;
  localparam int FIFO_DEPTH = 8;
  localparam int OCTET_W = 8;
  // ----------------------------------------
  // message type classes
  // ----------------------------------------
  localparam logic [2:0] MT_HI3_ANALOGUE = 3'h0;
  localparam logic [2:0] MT_HI3_BEARER = 3'h2;
  localparam logic [3:0] MT_HI4_CONTROL = 4'h2;
  localparam logic [3:0] MT_HI4_PROTECT = 4'h3;
  localparam logic [3:0] MT_HI4_LINK = 4'h6;
  typedef enum logic [2:0] {
    L3HC_CLS_ANALOGUE,
    L3HC_CLS_CONTROL,
    L3HC_CLS_PROTECT,
    L3HC_CLS_BEARER,
    L3HC_CLS_LINK,
    L3HC_CLS_RESERVED
  } l3hc_class_t;
endpackage

// [include/l3hc_if.sv]
// octet stream carrier between the layer 2 sender and the classifier
`timescale 1ns/100ps
interface l3hc_if;
  logic [7:0] data;
  logic valid;
  logic last;
  logic ready;
  modport sender (output data, output valid, output last, input ready);
  modport receiver (input data, input valid, input last, output ready);
endinterface

// [hw/l3hc_fifo.sv]
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/100ps
module l3hc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (push) begin
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
    end
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage carries no reset: contents are only read while counted valid
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

// [hw/l3hc_classifier.sv]
// receiving end: checks and classifies the message header, passes payload on
`timescale 1ns/100ps
// Notes on behaviour
// - message type is the single fourth octet
// - message type bit 8 must be zero
// - 000 analogue line, 010 bearer connection
// - 0010 control, 0011 protection, 0110 link
// - other message type patterns classed reserved
// - single codeset, no shift handling anywhere
// - elements follow header in fixed order
// - discriminator 0x48 then two address octets
// - bit 1 first, lower octets first
// - reserved nonzero bits raise no error, except message type bit 8
// - each element at most once per message
module l3hc_classifier (
  input wire logic mclk,
  input wire logic nrst,
  l3hc_if.receiver link,
  output logic hdr_valid,
  output logic [15:0] l3_address,
  output logic [6:0] msg_type,
  output l3hc_pkg::l3hc_class_t msg_class,
  output logic hdr_error,
  output logic [7:0] pay_data,
  output logic pay_valid,
  output logic pay_last,
  input wire logic pay_ready
);
  // ----------------------------------------
  // input buffer
  // ----------------------------------------
  logic [8:0] f_data;
  logic f_valid, f_ready, f_take;
  // eight octets of slack let the link run on while payload is held up

  l3hc_fifo #(.WIDTH(9), .DEPTH(l3hc_pkg::FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_data({link.last, link.data}),
    .in_valid(link.valid),
    .in_ready(f_ready),
    .out_data(f_data),
    .out_valid(f_valid),
    .out_ready(f_take)
  );
  assign link.ready = f_ready;

  // ----------------------------------------
  // header parse
  // ----------------------------------------
  typedef enum logic [2:0] {
    L3HC_H_PD,
    L3HC_H_AHI,
    L3HC_H_ALO,
    L3HC_H_TYPE,
    L3HC_H_BODY
  } l3hc_hstate_t;
  l3hc_hstate_t hs_q, hs_d;
  logic [15:0] addr_q, addr_d;
  logic bad_q, bad_d;
  logic hv_q, hv_d, err_q, err_d;
  logic [6:0] mt_q, mt_d;
  l3hc_pkg::l3hc_class_t cls_q, cls_d;
  logic [7:0] pd_q, pd_d;
  logic pv_q, pv_d, pl_q, pl_d;
  logic [7:0] oct;
  logic in_hdr, out_free;

  assign oct = f_data[7:0];
  assign in_hdr = (hs_q != L3HC_H_BODY);
  // payload register must be free before a payload octet is popped
  assign out_free = !pv_q || pay_ready;
  assign f_take = f_valid && (in_hdr || out_free);

  // ----------------------------------------
  // message type decode
  // ----------------------------------------
  // bit 8 is ignored here so a bad octet still gets a class for the error pulse
  function automatic l3hc_pkg::l3hc_class_t classify(input logic [7:0] m);
    classify = l3hc_pkg::L3HC_CLS_RESERVED;
    if (m[6:4] == l3hc_pkg::MT_HI3_ANALOGUE) begin
      classify = l3hc_pkg::L3HC_CLS_ANALOGUE;
    end else if (m[6:4] == l3hc_pkg::MT_HI3_BEARER) begin
      classify = l3hc_pkg::L3HC_CLS_BEARER;
    end else if (m[6:3] == l3hc_pkg::MT_HI4_CONTROL) begin
      classify = l3hc_pkg::L3HC_CLS_CONTROL;
    end else if (m[6:3] == l3hc_pkg::MT_HI4_PROTECT) begin
      classify = l3hc_pkg::L3HC_CLS_PROTECT;
    end else if (m[6:3] == l3hc_pkg::MT_HI4_LINK) begin
      classify = l3hc_pkg::L3HC_CLS_LINK;
    end
  endfunction

  always_comb begin
    hs_d = hs_q;
    addr_d = addr_q;
    bad_d = bad_q;
    mt_d = mt_q;
    cls_d = cls_q;
    // header flags are one-cycle pulses; the fields hold until the next header
    hv_d = 1'b0;
    err_d = 1'b0;
    if (f_take) begin
      // header octets carry no identifier: position alone says what they are
      case (hs_q)
        L3HC_H_PD: begin
          bad_d = (oct != l3hc_pkg::PD_VALUE);
          hs_d = L3HC_H_AHI;
        end
        L3HC_H_AHI: begin
          addr_d = {oct, addr_q[7:0]};
          hs_d = L3HC_H_ALO;
        end
        L3HC_H_ALO: begin
          addr_d = {addr_q[15:8], oct};
          hs_d = L3HC_H_TYPE;
        end
        L3HC_H_TYPE: begin
          // the single octet after the address is the message type
          mt_d = oct[6:0];
          cls_d = classify(oct);
          hv_d = 1'b1;
          err_d = bad_q;
          if (oct[l3hc_pkg::MT_SPARE_BIT]) begin
            err_d = 1'b1;
          end
          if (classify(oct) == l3hc_pkg::L3HC_CLS_RESERVED) begin
            err_d = 1'b1;
          end
          hs_d = L3HC_H_BODY;
        end
        L3HC_H_BODY: begin
          hs_d = L3HC_H_BODY;
        end
        default: begin
          hs_d = L3HC_H_PD;
        end
      endcase
      // a cut message restarts the header, without a header pulse
      if (f_data[8]) begin
        hs_d = L3HC_H_PD;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      hs_q <= L3HC_H_PD;
      addr_q <= 16'h0000;
      bad_q <= 1'b0;
      mt_q <= 7'h00;
      cls_q <= l3hc_pkg::L3HC_CLS_RESERVED;
      hv_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      hs_q <= hs_d;
      addr_q <= addr_d;
      bad_q <= bad_d;
      mt_q <= mt_d;
      cls_q <= cls_d;
      hv_q <= hv_d;
      err_q <= err_d;
    end
  end

  // ----------------------------------------
  // payload output
  // ----------------------------------------
  // one stage only: a stalled reader holds the fifo, and the fifo then holds the link
  always_comb begin
    pd_d = pd_q;
    pv_d = pv_q && !pay_ready;
    pl_d = pl_q;
    if (f_take && !in_hdr) begin
      // payload passes untouched: elements are not reordered or shifted
      // reserved payload bits are not checked
      pd_d = oct;
      pv_d = 1'b1;
      pl_d = f_data[8];
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      pd_q <= 8'h00;
      pv_q <= 1'b0;
      pl_q <= 1'b0;
    end else begin
      pd_q <= pd_d;
      pv_q <= pv_d;
      pl_q <= pl_d;
    end
  end

  // ----------------------------------------
  // outputs, all registered
  // ----------------------------------------
  assign hdr_valid = hv_q;
  assign l3_address = addr_q;
  assign msg_type = mt_q;
  assign msg_class = cls_q;
  assign hdr_error = err_q;
  assign pay_data = pd_q;
  assign pay_valid = pv_q;
  assign pay_last = pl_q;
endmodule

// [hw/l3hc_sender.sv]
// sending end: serialises header and element octets onto the link
`timescale 1ns/100ps
module l3hc_sender (
  input wire logic mclk,
  input wire logic nrst,
  l3hc_if.sender link,
  input wire logic start,
  input wire logic [15:0] l3_address,
  input wire logic [6:0] msg_type,
  input wire logic [7:0] el_data,
  input wire logic el_valid,
  input wire logic el_last,
  output logic el_ready,
  output logic busy
);
  typedef enum logic [2:0] {
    L3HC_S_IDLE, L3HC_S_PD, L3HC_S_AH, L3HC_S_AL, L3HC_S_MT, L3HC_S_EL
  } l3hc_sstate_t;
  l3hc_sstate_t st_q, st_d;
  logic [15:0] a_q, a_d;
  logic [6:0] m_q, m_d;
  logic [7:0] dat_q, dat_d;
  logic v_q, v_d, l_q, l_d, rd_q, rd_d;
  logic busy_q, busy_d;
  logic free;

  assign free = !v_q || link.ready;

  always_comb begin
    st_d = st_q;
    a_d = a_q;
    m_d = m_q;
    dat_d = dat_q;
    v_d = v_q && !link.ready;
    l_d = l_q;
    rd_d = 1'b0;
    case (st_q)
      L3HC_S_IDLE: begin
        if (start) begin
          a_d = l3_address;
          m_d = msg_type;
          st_d = L3HC_S_PD;
        end
      end
      L3HC_S_PD: begin
        if (free) begin
          dat_d = l3hc_pkg::PD_VALUE;
          v_d = 1'b1;
          l_d = 1'b0;
          st_d = L3HC_S_AH;
        end
      end
      L3HC_S_AH: begin
        if (free) begin
          dat_d = a_q[15:8];
          v_d = 1'b1;
          st_d = L3HC_S_AL;
        end
      end
      L3HC_S_AL: begin
        if (free) begin
          dat_d = a_q[7:0];
          v_d = 1'b1;
          st_d = L3HC_S_MT;
        end
      end
      L3HC_S_MT: begin
        if (free) begin
          dat_d = {1'b0, m_q};
          v_d = 1'b1;
          st_d = L3HC_S_EL;
        end
      end
      L3HC_S_EL: begin
        // elements come ordered, unique, one codeset, reserved bits zero
        if (free && el_valid && !rd_q) begin
          dat_d = el_data;
          v_d = 1'b1;
          l_d = el_last;
          rd_d = 1'b1;
          if (el_last) begin
            st_d = L3HC_S_IDLE;
          end
        end
      end
      default: begin
        st_d = L3HC_S_IDLE;
      end
    endcase
    busy_d = (st_d != L3HC_S_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_q <= L3HC_S_IDLE;
      a_q <= 16'h0000;
      m_q <= 7'h00;
      dat_q <= 8'h00;
      v_q <= 1'b0;
      l_q <= 1'b0;
      rd_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      a_q <= a_d;
      m_q <= m_d;
      dat_q <= dat_d;
      v_q <= v_d;
      l_q <= l_d;
      rd_q <= rd_d;
      busy_q <= busy_d;
    end
  end

  assign link.data = dat_q;
  assign link.valid = v_q;
  assign link.last = l_q;
  assign el_ready = rd_q;
  assign busy = busy_q;
endmodule

// [bench/l3hc_assertions.sv]
// link assertions for the classifier pair
`timescale 1ns/100ps
module l3hc_assertions (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] data,
  input wire logic valid,
  input wire logic last,
  input wire logic ready
);
  // header position, saturates past the type octet
  logic [2:0] pos_q;
  logic [2:0] pos_d;
  always_comb begin
    pos_d = pos_q;
    if (valid && ready) begin
      pos_d = last ? 3'h0 : pos_q + {2'h0, pos_q != 3'h4};
    end
  end
  always_ff @(posedge mclk) begin
    pos_q <= nrst ? pos_d : 3'h0;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_take;
    valid && ready;
  endsequence
  sequence s_end;
    valid && ready && last;
  endsequence
  a_pd_first: assert property (s_take ##0 pos_q == 3'h0 |-> data == l3hc_pkg::PD_VALUE)
    else $error("bad discriminator");
  a_pd_restart: assert property (s_end |=> !valid || data == l3hc_pkg::PD_VALUE)
    else $error("bad restart");
  a_type_spare: assert property (s_take ##0 pos_q == 3'h3 |-> !data[7])
    else $error("type bit 8 set");
  a_hdr_whole: assert property (s_take ##0 pos_q < 3'h3 |-> !last)
    else $error("short header");
  a_hdr_gapless: assert property (s_take ##0 pos_q < 3'h3 |=> valid)
    else $error("header gap");
  a_data_held: assert property (valid && !ready |=> valid && $stable(data))
    else $error("octet dropped");
  a_last_held: assert property (valid && !ready |=> $stable(last))
    else $error("last moved");
  a_reset_idle: assert property (disable iff (1'b0) !nrst |=> !valid && ready)
    else $error("not idle");
endmodule

// [bench/l3_message_header_classifier_bench.sv]
// bench: sender and classifier back to back, raw driver on a second link
`timescale 1ns/100ps
module l3_message_header_classifier_bench;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic [15:0] adr = 16'h0000;
  logic [6:0] mt = 7'h00;
  logic [7:0] ed = 8'h00;
  logic ev = 1'b0;
  logic el = 1'b0;
  logic pr = 1'b1;
  logic er, hv, he, pv, hv2, he2, hx, bx, pl, sb;
  logic [15:0] la, ha;
  logic [6:0] omt, ht;
  logic [7:0] pd;
  logic [7:0] pq[$];
  l3hc_pkg::l3hc_class_t oc, hc;
  int err_count = 0;
  int n_compared = 0;
  int hn = 0;
  int bn = 0;
  int pln = -1;
  l3hc_if lk();
  l3hc_if lk2();
  always #25 mclk = ~mclk;
  l3hc_sender u_l3hc_sender (.mclk(mclk), .nrst(nrst), .link(lk), .start(start),
    .l3_address(adr), .msg_type(mt), .el_data(ed), .el_valid(ev), .el_last(el),
    .el_ready(er), .busy(sb));
  l3hc_classifier u_l3hc_classifier (.mclk(mclk), .nrst(nrst), .link(lk), .hdr_valid(hv),
    .l3_address(la), .msg_type(omt), .msg_class(oc), .hdr_error(he), .pay_data(pd),
    .pay_valid(pv), .pay_last(pl), .pay_ready(pr));
  l3hc_classifier u_l3hc_classifier_raw (.mclk(mclk), .nrst(nrst), .link(lk2),
    .hdr_valid(hv2), .l3_address(), .msg_type(), .msg_class(), .hdr_error(he2),
    .pay_data(), .pay_valid(), .pay_last(), .pay_ready(1'b1));
  l3hc_assertions u_l3hc_assertions (.mclk(mclk), .nrst(nrst), .data(lk.data),
    .valid(lk.valid), .last(lk.last), .ready(lk.ready));
  always @(posedge mclk) begin
    if (hv) begin
      hn++;
      ha = la;
      ht = omt;
      hc = oc;
      hx = he;
    end
    if (hv2) begin
      bn++;
      bx = he2;
    end
    if (pv && pr) begin
      if (pl) pln = pq.size();
      pq.push_back(pd);
    end
  end
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tmo();
    err_count++;
    summarize();
  endtask
  // element octets hold until the take pulse
  task automatic snd(input logic [15:0] a, input logic [6:0] t, input int n);
    int k;
    @(negedge mclk);
    start = 1'b1;
    adr = a;
    mt = t;
    @(negedge mclk);
    start = 1'b0;
    for (int i = 0; i < n; i++) begin
      ed = 8'hA0 + 8'(i);
      ev = 1'b1;
      el = (i == n - 1);
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (!er && k < 300);
      if (!er) tmo();
      @(negedge mclk);
    end
    ev = 1'b0;
    el = 1'b0;
    ed = ~ed;
  endtask
  task automatic fin(input int n, input int h, input logic [15:0] a, input logic [6:0] t,
      input l3hc_pkg::l3hc_class_t c, input logic e);
    int k;
    k = 0;
    while ((pq.size() < n || hn < h) && k < 300) begin
      @(negedge mclk);
      k++;
    end
    if (k == 300) tmo();
    chk("address", ha, a);
    chk("type", 16'(ht), 16'(t));
    chk("class", 16'(hc), 16'(c));
    chk("error", 16'(hx), 16'(e));
    for (int i = 0; i < n; i++) chk("payload", 16'(pq[i]), 16'(8'hA0 + 8'(i)));
    chk("pay last", 16'(pln), 16'(n - 1));
    chk("sender busy", 16'(sb), 16'h0000);
    pq.delete();
    pln = -1;
  endtask
  // raw octets on the second link, for faults the sender cannot make
  task automatic raw(input logic [7:0] b0, input logic [7:0] b3);
    logic [7:0] o[5];
    int k;
    o = '{b0, 8'h12, 8'h34, b3, 8'h99};
    foreach (o[i]) begin
      @(negedge mclk);
      lk2.data = o[i];
      lk2.valid = 1'b1;
      lk2.last = (i == 4);
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (!lk2.ready && k < 50);
      if (!lk2.ready) tmo();
    end
    @(negedge mclk);
    lk2.valid = 1'b0;
    lk2.last = 1'b0;
    lk2.data = ~lk2.data;
  endtask
  localparam logic [6:0] TT[6] = '{7'h0F, 7'h17, 7'h18, 7'h2F, 7'h30, 7'h38};
  localparam l3hc_pkg::l3hc_class_t TC[6] = '{l3hc_pkg::L3HC_CLS_ANALOGUE,
    l3hc_pkg::L3HC_CLS_CONTROL, l3hc_pkg::L3HC_CLS_PROTECT, l3hc_pkg::L3HC_CLS_BEARER,
    l3hc_pkg::L3HC_CLS_LINK, l3hc_pkg::L3HC_CLS_RESERVED};
  localparam logic [7:0] BB[3] = '{8'h49, 8'h48, 8'h48};
  localparam logic [7:0] BT[3] = '{8'h05, 8'h85, 8'h25};
  initial begin
    int k;
    lk2.data = 8'h00;
    lk2.valid = 1'b0;
    lk2.last = 1'b0;
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    for (int i = 0; i < 6; i++) begin
      snd(16'hC0DE + 16'(i), TT[i], i + 1);
      fin(i + 1, i + 1, 16'hC0DE + 16'(i), TT[i], TC[i], i == 5);
    end
    // far side stalls until the link refuses, then drains
    pr = 1'b0;
    fork
      snd(16'h0F0F, 7'h33, 14);
      begin
        k = 0;
        while (lk.ready && k < 300) begin
          @(negedge mclk);
          k++;
        end
        chk("link ready", 16'(lk.ready), 16'h0000);
        chk("sender busy", 16'(sb), 16'h0001);
        repeat (4) @(negedge mclk);
        pr = 1'b1;
      end
    join
    fin(14, 7, 16'h0F0F, 7'h33, l3hc_pkg::L3HC_CLS_LINK, 1'b0);
    for (int i = 0; i < 3; i++) begin
      raw(BB[i], BT[i]);
      k = 0;
      while (bn < i + 1 && k < 50) begin
        @(negedge mclk);
        k++;
      end
      if (k == 50) tmo();
      chk("raw error", 16'(bx), 16'(i < 2));
    end
    summarize();
  end
endmodule
